// [three_port_gpio_data_regs_tb_top.sv]
`timescale 1ns/10ps
`include "tpg_defines.vh"
// Self-checking bench for the three port data registers
module three_port_gpio_data_regs_tb_top;
  reg         ref_clk = 1'b0;  // 50 MHz clock
  reg         rstn = 1'b0;     // Power-on reset
  reg         mr = 1'b0;       // Manual reset
  reg         req = 1'b0;      // Access strobe
  reg         we = 1'b0;       // Write select
  reg  [31:0] addr = 32'h0;    // Access address
  reg  [7:0]  wd = 8'h00;      // Write byte
  reg  [15:0] mb = 16'haaaa;   // Port modes
  reg  [15:0] mc = 16'haaaa;
  reg  [15:0] md = 16'haaaa;
  reg         en = 1'b0;       // Board drives pins
  reg  [7:0]  dv = 8'h00;      // Board level
  wire [7:0]  rd, ob, oc, od, eb, ec, ed, ub, uc, ud, lb, lc, ld;
  wire        ack, miss;
  integer     num_errors = 0;
  integer     num_checks = 0;
  always #10 ref_clk = ~ref_clk;
  tpg_top dut (.ref_clk(ref_clk), .rstn(rstn), .manual_reset(mr), .bus_req(req), .bus_we(we),
    .bus_addr(addr), .bus_wdata(wd), .bus_rdata(rd), .bus_ack(ack), .bus_miss(miss),
    .port_b_mode_control(mb), .port_c_mode_control(mc), .port_d_mode_control(md),
    .port_b_pin_in(lb), .port_c_pin_in(lc), .port_d_pin_in(ld),
    .port_b_pin_out(ob), .port_c_pin_out(oc), .port_d_pin_out(od),
    .port_b_pin_oe(eb), .port_c_pin_oe(ec), .port_d_pin_oe(ed),
    .port_b_pull_up(ub), .port_c_pull_up(uc), .port_d_pull_up(ud));
  tpg_board bb (.ref_clk(ref_clk), .drv_en(en), .drv_val(dv), .pin_out(ob), .pin_oe(eb), .pull_up(ub), .level(lb));
  tpg_board bc (.ref_clk(ref_clk), .drv_en(en), .drv_val(dv), .pin_out(oc), .pin_oe(ec), .pull_up(uc), .level(lc));
  tpg_board bd (.ref_clk(ref_clk), .drv_en(en), .drv_val(dv), .pin_out(od), .pin_oe(ed), .pull_up(ud), .level(ld));
  // Compare and count
  task chk(input [7:0] seen, input [7:0] exp);
  begin
    num_checks = num_checks + 1;
    if (seen !== exp)
    begin
      num_errors = num_errors + 1;
      $display("mismatch at %0t: saw %h expected %h", $time, seen, exp);
    end
  end
  endtask
  // One access: strobe one cycle, answer due one cycle later
  task acc(input w, input [31:0] a, input [7:0] d, input [7:0] exp, input m);
  begin
    @(negedge ref_clk);
    req = 1'b1; we = w; addr = a; wd = d;
    @(negedge ref_clk);
    req = 1'b0;
    chk({6'h0, ack, miss}, {6'h0, 1'b1, m});
    if (!w) chk(rd, exp);
  end
  endtask
  // State straight after power-on
  task t_reset;
  begin
    chk(ub, 8'hff);
    chk(eb, 8'h00);
    chk(ob, 8'h00);
    chk(od & 8'haf, 8'h00);
    repeat (6) @(negedge ref_clk);
    acc(1'b0, `TPG_PB_ADDR, 8'h00, 8'hff, 1'b0);
    $display("test reset done");
  end
  endtask
  // Every mode on port B
  task t_modes;
    integer i;
    reg [1:0] m;
  begin
    en = 1'b1; dv = 8'ha5;
    for (i = 0; i < 4; i = i + 1)
    begin
      m = i;
      mb = {8{m}};
      acc(1'b1, `TPG_PB_ADDR, 8'h3c ^ i[7:0], 8'h00, 1'b0);
      repeat (6) @(negedge ref_clk);
      chk(ob, 8'h3c ^ i[7:0]);
      chk(eb, (m == `TPG_MODE_OUT) ? 8'hff : 8'h00);
      chk(ub, (m == `TPG_MODE_IN_PU) ? 8'hff : 8'h00);
      chk(lb, (m == `TPG_MODE_OUT) ? 8'h3c ^ i[7:0] : 8'ha5);
      acc(1'b0, `TPG_PB_ADDR, 8'h00, m[1] ? 8'ha5 : 8'h3c ^ i[7:0], 1'b0);
    end
    $display("test modes done");
  end
  endtask
  // Port D input-only bits in every mode
  task t_port_d;
    integer i;
    reg [1:0] m;
  begin
    dv = 8'h5a;
    for (i = 0; i < 4; i = i + 1)
    begin
      m = i;
      md = {8{m}};
      acc(1'b1, `TPG_PD_ADDR, 8'hff, 8'h00, 1'b0);
      repeat (6) @(negedge ref_clk);
      chk(od, 8'haf);
      chk(ed, (m == `TPG_MODE_OUT) ? 8'haf : 8'h00);
      chk(ud, (m == `TPG_MODE_IN_PU) ? 8'hff : 8'h00);
      acc(1'b0, `TPG_PD_ADDR, 8'h00, m[1] ? 8'h5a : 8'haf, 1'b0);
    end
    $display("test port d done");
  end
  endtask
  // Alias, unmapped address, manual reset
  task t_alias;
  begin
    mc = 16'h5555;
    acc(1'b1, `TPG_PC_ADDR | `TPG_ALIAS_BIT, 8'h96, 8'h00, 1'b0);
    chk(ec, 8'hff);
    chk(uc, 8'h00);
    acc(1'b0, `TPG_PC_ADDR, 8'h00, 8'h96, 1'b0);
    acc(1'b0, 32'h04000128, 8'h00, 8'h00, 1'b1);
    mr = 1'b1;
    repeat (2) @(negedge ref_clk);
    mr = 1'b0;
    acc(1'b0, `TPG_PC_ADDR | `TPG_ALIAS_BIT, 8'h00, 8'h96, 1'b0);
    chk(oc, 8'h96);
    $display("test alias done");
  end
  endtask
  // Power-on reset in mid-run
  task t_por;
  begin
    rstn = 1'b0;
    // Mode registers return to input with pull-up at power-on too
    mb = 16'haaaa;
    mc = 16'haaaa;
    md = 16'haaaa;
    @(negedge ref_clk);
    chk(oc, 8'h00);
    chk(od & 8'haf, 8'h00);
    chk(ub, 8'hff);
    rstn = 1'b1;
    repeat (6) @(negedge ref_clk);
    acc(1'b0, `TPG_PB_ADDR, 8'h00, 8'h5a, 1'b0);
    acc(1'b0, `TPG_PD_ADDR, 8'h00, 8'h5a, 1'b0);
    chk(ob, 8'h00);
    chk(eb | ed, 8'h00);
    $display("test power reset done");
  end
  endtask
  // Verdict and end of run
  task complete_run;
  begin
    $display("checks %0d mismatches %0d", num_checks, num_errors);
    if (num_errors == 0 && num_checks > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  end
  endtask
  // Main sequence
  initial
  begin
    repeat (4) @(negedge ref_clk);
    rstn = 1'b1;
    t_reset;
    t_modes;
    t_port_d;
    t_alias;
    t_por;
    complete_run;
  end
  // Watchdog at 5000 cycles, far beyond the roughly 113 cycles needed
  initial
  begin
    #100000;
    num_errors = num_errors + 1;
    complete_run;
  end
endmodule // three_port_gpio_data_regs_tb_top

// [tpg_board.sv]
`timescale 1ns/10ps
// Board wiring around one port
module tpg_board (
  input  wire       ref_clk,  // Clock for the float pattern
  input  wire       drv_en,   // Board drives the pins
  input  wire [7:0] drv_val,  // Level the board drives
  input  wire [7:0] pin_out,  // Device driven values
  input  wire [7:0] pin_oe,   // Device driver enables
  input  wire [7:0] pull_up,  // Device pull-up enables
  output wire [7:0] level     // Resolved pin levels
);
  reg [7:0] flt = 8'h55;  // Floating pins wander so no stale value passes
  // Toggle every cycle
  always @(posedge ref_clk)
  begin
    flt <= ~flt;
  end
  // Device driver wins, then board, then pull-up, else float
  assign level = (pin_oe & pin_out) | (~pin_oe & (drv_en ? drv_val : (pull_up | flt)));
endmodule // tpg_board

// [tpg_defines.vh]
`ifndef TPG_DEFINES_VH
`define TPG_DEFINES_VH

// Data register addresses: physical and untranslated alias
`define TPG_PB_ADDR      32'h04000122
`define TPG_PC_ADDR      32'h04000124
`define TPG_PD_ADDR      32'h04000126
`define TPG_ALIAS_BIT    32'ha0000000

// Port index inside the packed 24-bit vectors
`define TPG_PORT_B       0
`define TPG_PORT_C       1
`define TPG_PORT_D       2

// Pin mode codes, two bits per pin
`define TPG_MODE_ALT     2'h0
`define TPG_MODE_OUT     2'h1
`define TPG_MODE_IN_PU   2'h2
`define TPG_MODE_IN_NOPU 2'h3

// Mode field of pin n sits at bits 2n+1..2n
`define TPG_MODE_W       2

// Writable bits per port; port D bits 6 and 4 are input only
`define TPG_WR_MASK_B    8'hff
`define TPG_WR_MASK_C    8'hff
`define TPG_WR_MASK_D    8'haf

// Power-on reset values
`define TPG_DATA_RST     8'h00
`define TPG_PU_RST       8'hff
`define TPG_OE_RST       8'h00
`define TPG_SYNC_RST     8'hff
`define TPG_RDATA_RST    8'h00

`endif

// [tpg_pad_ctl.v]
`timescale 1ns/10ps
`include "tpg_defines.vh"

// Registered pad controls for one 8-pin port
module tpg_pad_ctl #(
  parameter [7:0] WR_MASK = `TPG_WR_MASK_B  // Bits that may drive a pin
) (
  input  wire        ref_clk,  // System clock
  input  wire        rstn,     // Power-on reset, active low
  input  wire [15:0] mode,     // Two mode bits per pin
  output reg  [7:0]  pin_oe,   // Output driver enable, high drives
  output reg  [7:0]  pull_up   // Input pull-up enable
);

  // Reset levels per bit, so each flop takes exactly one constant bit
  localparam [7:0] OE_RST = `TPG_OE_RST;
  localparam [7:0] PU_RST = `TPG_PU_RST;

  // One decoder per pin; flops keep the pad outputs glitch free
  genvar i;
  generate
    for (i = 0; i < 8; i = i + 1)
    begin : g_pin
      always @(posedge ref_clk or negedge rstn)
      begin
        if (!rstn)
        begin
          pin_oe[i]  <= OE_RST[i];  // R8
          pull_up[i] <= PU_RST[i];  // R8
        end
        else
        begin
          // Driver only in general output, never on input-only bits
          pin_oe[i]  <= WR_MASK[i] &&
                        (mode[`TPG_MODE_W*i +: `TPG_MODE_W] == `TPG_MODE_OUT);  // R16
          // Pull-up only in mode 10; 11 releases it
          pull_up[i] <= (mode[`TPG_MODE_W*i +: `TPG_MODE_W] == `TPG_MODE_IN_PU);  // R14
        end
      end
    end
  endgenerate

endmodule // tpg_pad_ctl

// [tpg_pin_sync.v]
`timescale 1ns/10ps
`include "tpg_defines.vh"

// Three-stage synchroniser for eight pin levels
module tpg_pin_sync (
  input  wire       ref_clk,   // System clock
  input  wire       rstn,      // Power-on reset, active low
  input  wire [7:0] pin_raw,   // Asynchronous pin levels
  output reg  [7:0] pin_level  // Accepted, debounced level
);

  reg [7:0] stage1;            // Metastability catcher, read by stage2 only
  reg [7:0] stage2;            // Second stage
  reg [7:0] stage3;            // Third stage

  // Idle level per bit, so each pin_level flop takes exactly one constant bit
  localparam [7:0] SYNC_RST = `TPG_SYNC_RST;

  // Shift chain; resets to the pulled-up idle level
  always @(posedge ref_clk or negedge rstn)
  begin
    if (!rstn)
    begin
      stage1 <= `TPG_SYNC_RST;
      stage2 <= `TPG_SYNC_RST;
      stage3 <= `TPG_SYNC_RST;
    end
    else
    begin
      stage1 <= pin_raw;
      stage2 <= stage1;
      stage3 <= stage2;
    end
  end

  // A change counts only once stages two and three agree
  genvar i;
  generate
    for (i = 0; i < 8; i = i + 1)
    begin : g_bit
      always @(posedge ref_clk or negedge rstn)
      begin
        if (!rstn)
          pin_level[i] <= SYNC_RST[i];
        else if (stage2[i] == stage3[i])
          pin_level[i] <= stage3[i];
      end
    end
  endgenerate

endmodule // tpg_pin_sync

// [tpg_properties.sv]
`timescale 1ns/10ps
`include "tpg_defines.vh"
// Pad and bus relations watched from the top ports
module tpg_props (
  input wire        ref_clk,
  input wire        rstn,
  input wire        manual_reset,
  input wire        bus_req,
  input wire        bus_we,
  input wire [31:0] bus_addr,
  input wire [7:0]  bus_wdata,
  input wire [7:0]  bus_rdata,
  input wire        bus_ack,
  input wire [15:0] port_b_mode_control,
  input wire [15:0] port_d_mode_control,
  input wire [7:0]  port_b_pin_out,
  input wire [7:0]  port_c_pin_out,
  input wire [7:0]  port_d_pin_out,
  input wire [7:0]  port_b_pin_oe,
  input wire [7:0]  port_d_pin_oe,
  input wire [7:0]  port_b_pull_up
);
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (!rstn);
  // Write taken at one address
  sequence s_wr(a);
    bus_req && bus_we && bus_addr == a;
  endsequence
  // Read of port B with every pin in output mode
  sequence s_rd_b;
    bus_req && !bus_we && bus_addr == `TPG_PB_ADDR && port_b_mode_control == 16'h5555 && !manual_reset;
  endsequence
  property p_ack; bus_req && !manual_reset |=> bus_ack; endproperty
  property p_wr_b; s_wr(`TPG_PB_ADDR) |=> port_b_pin_out == $past(bus_wdata); endproperty
  property p_alias; s_wr(32'ha4000124) |=> port_c_pin_out == $past(bus_wdata); endproperty
  property p_hold; !(bus_req && bus_we) |=> $stable(port_b_pin_out); endproperty
  property p_rd; s_rd_b |=> bus_rdata == port_b_pin_out; endproperty
  property p_oe; port_b_pin_oe[0] == ($past(port_b_mode_control[1:0]) == `TPG_MODE_OUT); endproperty
  property p_pu; port_b_pull_up[0] == ($past(port_b_mode_control[1:0]) == `TPG_MODE_IN_PU); endproperty
  property p_d_ro; ((port_d_pin_oe | port_d_pin_out) & 8'h50) == 8'h00; endproperty
  property p_d_low;
    bus_req && !bus_we && bus_addr == `TPG_PD_ADDR && !port_d_mode_control[13] && !manual_reset
      |=> !bus_rdata[6];
  endproperty
  property p_por;
    $rose(rstn) |-> port_b_pin_out == 8'h00 && port_c_pin_out == 8'h00 && (port_d_pin_out & 8'haf) == 8'h00;
  endproperty
  a_ack: assert property (p_ack) else $error("no answer after request");
  a_wr_b: assert property (p_wr_b) else $error("port b write lost");
  a_alias: assert property (p_alias) else $error("alias write lost");
  a_hold: assert property (p_hold) else $error("port b data moved");
  a_rd: assert property (p_rd) else $error("output mode read wrong");
  a_oe: assert property (p_oe) else $error("driver enable wrong");
  a_pu: assert property (p_pu) else $error("pull-up wrong");
  a_d_ro: assert property (p_d_ro) else $error("input-only bit driven");
  a_d_low: assert property (p_d_low) else $error("bit 6 not low");
  a_por: assert property (p_por) else $error("data not cleared");
endmodule // tpg_props
bind tpg_top tpg_props u_props (.ref_clk(ref_clk), .rstn(rstn), .manual_reset(manual_reset),
  .bus_req(bus_req), .bus_we(bus_we), .bus_addr(bus_addr), .bus_wdata(bus_wdata),
  .bus_rdata(bus_rdata), .bus_ack(bus_ack), .port_b_mode_control(port_b_mode_control),
  .port_d_mode_control(port_d_mode_control), .port_b_pin_out(port_b_pin_out),
  .port_c_pin_out(port_c_pin_out), .port_d_pin_out(port_d_pin_out),
  .port_b_pin_oe(port_b_pin_oe), .port_d_pin_oe(port_d_pin_oe), .port_b_pull_up(port_b_pull_up));

// [tpg_top.v]
`timescale 1ns/10ps
`include "tpg_defines.vh"

// Function
// R1: Full ports hold 8-bit data, bit n to pin n
// R2: Output or alternate mode reads stored bit
// R3: Input modes read the synchronised pin level
// R4: Mode 00 alt, 01 out, 10/11 input
// R5: Non-output writes store but leave pins alone
// R6: Power-on reset clears full port data
// R7: Manual reset and low power keep data
// R8: Pins default to input with pull-up
// R9: Port D bits 6, 4 are read-only
// R10: Power-on reset clears port D writable bits
// R11: Port D bits 6, 4 read low unless input
// R12: Writes to port D bits 6, 4 ignored
// R13: Other port D bits behave like full ports
// R14: Pull-up on in mode 10, off in 11
// R15: Registers answer at physical and alias address
// R16: Pin driver enabled only in output mode
module tpg_top (
  input  wire        ref_clk,              // System clock, 50 MHz
  input  wire        rstn,                 // Power-on reset, active low
  input  wire        manual_reset,         // Manual reset level, high active
  input  wire        bus_req,              // Access strobe, one cycle
  input  wire        bus_we,               // High write, low read
  input  wire [31:0] bus_addr,             // Byte address
  input  wire [7:0]  bus_wdata,            // Write byte
  output reg  [7:0]  bus_rdata,            // Read byte
  output reg         bus_ack,              // Access answered
  output reg         bus_miss,             // Address matched no register
  input  wire [15:0] port_b_mode_control,  // Port B pin modes
  input  wire [15:0] port_c_mode_control,  // Port C pin modes
  input  wire [15:0] port_d_mode_control,  // Port D pin modes
  input  wire [7:0]  port_b_pin_in,        // Port B pin levels
  input  wire [7:0]  port_c_pin_in,        // Port C pin levels
  input  wire [7:0]  port_d_pin_in,        // Port D pin levels
  output wire [7:0]  port_b_pin_out,       // Port B driven values
  output wire [7:0]  port_c_pin_out,       // Port C driven values
  output wire [7:0]  port_d_pin_out,       // Port D driven values
  output wire [7:0]  port_b_pin_oe,        // Port B driver enables
  output wire [7:0]  port_c_pin_oe,        // Port C driver enables
  output wire [7:0]  port_d_pin_oe,        // Port D driver enables
  output wire [7:0]  port_b_pull_up,       // Port B pull-up enables
  output wire [7:0]  port_c_pull_up,       // Port C pull-up enables
  output wire [7:0]  port_d_pull_up        // Port D pull-up enables
);

  // Packed views, port B in the lowest slice, port D in the highest slice
  wire [47:0] mode_all;                    // All pin modes
  wire [23:0] pin_raw_all;                 // All raw pin levels
  wire [23:0] pin_level_all;               // All synchronised levels
  wire [23:0] pin_oe_all;                  // All driver enables
  wire [23:0] pull_up_all;                 // All pull-up enables
  wire [23:0] wr_mask_all;                 // All writable bit masks
  wire [23:0] read_all;                    // All read views
  wire [2:0]  hit;                         // One-hot register match
  reg  [23:0] data_all;                    // Stored data bits
  reg  [7:0]  next_rdata;                  // Selected read byte

  // Writable masks as a constant, so the pad blocks can take them as parameters
  localparam [23:0] WR_MASK_ALL = {`TPG_WR_MASK_D, `TPG_WR_MASK_C, `TPG_WR_MASK_B};

  assign mode_all    = {port_d_mode_control, port_c_mode_control,
                        port_b_mode_control};
  assign pin_raw_all = {port_d_pin_in, port_c_pin_in, port_b_pin_in};
  assign wr_mask_all = WR_MASK_ALL;

  // Address match at the physical address or its untranslated alias
  function tpg_addr_hit;
    input [31:0] addr;                     // Address on the bus
    input [31:0] phys;                     // Physical register address
    begin
      tpg_addr_hit = (addr == phys) ||
                     (addr == (phys | `TPG_ALIAS_BIT));  // R15
    end
  endfunction

  // True when a pin mode selects general input
  function tpg_is_input;
    input [1:0] mode;                      // One pin's mode field
    begin
      tpg_is_input = (mode == `TPG_MODE_IN_PU) ||
                     (mode == `TPG_MODE_IN_NOPU);  // R4
    end
  endfunction

  // Per-bit read view of one port
  function [7:0] tpg_read_view;
    input [7:0]  stored;                   // Data register bits
    input [7:0]  level;                    // Synchronised pin levels
    input [15:0] mode;                     // Pin modes
    input [7:0]  wr_mask;                  // Writable bits
    integer      n;
    begin
      tpg_read_view = 8'h00;
      for (n = 0; n < 8; n = n + 1)
      begin
        if (tpg_is_input(mode[`TPG_MODE_W*n +: `TPG_MODE_W]))
          tpg_read_view[n] = level[n];     // R3
        else if (wr_mask[n])
          tpg_read_view[n] = stored[n];    // R2
        else
          tpg_read_view[n] = 1'b0;         // R11
      end
    end
  endfunction

  // Register decode, one match line per port
  assign hit[`TPG_PORT_B] = tpg_addr_hit(bus_addr, `TPG_PB_ADDR);
  assign hit[`TPG_PORT_C] = tpg_addr_hit(bus_addr, `TPG_PC_ADDR);
  assign hit[`TPG_PORT_D] = tpg_addr_hit(bus_addr, `TPG_PD_ADDR);

  // Per-port pin logic, identical apart from the writable mask
  genvar p;
  generate
    for (p = 0; p < 3; p = p + 1)
    begin : g_port
      // Pins arrive from the board, so they pass four flops
      tpg_pin_sync u_sync (
        .ref_clk   (ref_clk),
        .rstn      (rstn),
        .pin_raw   (pin_raw_all[8*p +: 8]),
        .pin_level (pin_level_all[8*p +: 8])
      );

      // Registered driver and pull-up controls
      tpg_pad_ctl #(
        .WR_MASK (WR_MASK_ALL[8*p +: 8])
      ) u_pad (
        .ref_clk (ref_clk),
        .rstn    (rstn),
        .mode    (mode_all[16*p +: 16]),
        .pin_oe  (pin_oe_all[8*p +: 8]),
        .pull_up (pull_up_all[8*p +: 8])
      );

      // Data bits: only the power-on reset clears them. Manual reset,
      // standby and sleep leave them alone, so none of those reaches
      // this process.
      always @(posedge ref_clk or negedge rstn)
      begin
        if (!rstn)
          data_all[8*p +: 8] <= `TPG_DATA_RST;  // R6 R10
        else if (bus_req && bus_we && hit[p])
          // Any mode stores the byte; read-only bits keep their zero
          data_all[8*p +: 8] <= (bus_wdata & wr_mask_all[8*p +: 8]) |
                                (data_all[8*p +: 8] &
                                 ~wr_mask_all[8*p +: 8]);  // R1 R5 R9 R12 R13
      end

      // Read view combines stored bits and live levels by mode
      assign read_all[8*p +: 8] = tpg_read_view(data_all[8*p +: 8],
                                                pin_level_all[8*p +: 8],
                                                mode_all[16*p +: 16],
                                                wr_mask_all[8*p +: 8]);  // R13
    end
  endgenerate

  // Read byte selection; an unmapped address reads zero
  always @*
  begin
    next_rdata = `TPG_RDATA_RST;
    case (hit)
      3'h1:
        next_rdata = read_all[8*`TPG_PORT_B +: 8];
      3'h2:
        next_rdata = read_all[8*`TPG_PORT_C +: 8];
      3'h4:
        next_rdata = read_all[8*`TPG_PORT_D +: 8];
      default:
        next_rdata = `TPG_RDATA_RST;
    endcase
  end

  // Bus answer: one cycle after the strobe, for reads and writes alike.
  // Manual reset only clears the answer state, never the data bits.
  always @(posedge ref_clk or negedge rstn)
  begin
    if (!rstn)
    begin
      bus_ack   <= 1'b0;
      bus_miss  <= 1'b0;
      bus_rdata <= `TPG_RDATA_RST;
    end
    else if (manual_reset)
    begin
      // Data registers stay untouched here
      bus_ack   <= 1'b0;                   // R7
      bus_miss  <= 1'b0;
      bus_rdata <= `TPG_RDATA_RST;
    end
    else
    begin
      bus_ack  <= bus_req;
      bus_miss <= bus_req && (hit == 3'h0);
      // Read data is captured at the strobe; it holds until the next read, a manual reset or a power-on reset
      if (bus_req && !bus_we)
        bus_rdata <= next_rdata;           // R2 R3
    end
  end

  // Pin values come straight from the data flops; the enable decides
  // whether they reach the pad, so other modes leave the pin unaffected
  assign port_b_pin_out = data_all[8*`TPG_PORT_B +: 8];  // R5
  assign port_c_pin_out = data_all[8*`TPG_PORT_C +: 8];
  assign port_d_pin_out = data_all[8*`TPG_PORT_D +: 8];

  // Pad controls come from the registered pad blocks
  assign port_b_pin_oe  = pin_oe_all[8*`TPG_PORT_B +: 8];  // R16
  assign port_c_pin_oe  = pin_oe_all[8*`TPG_PORT_C +: 8];
  assign port_d_pin_oe  = pin_oe_all[8*`TPG_PORT_D +: 8];
  assign port_b_pull_up = pull_up_all[8*`TPG_PORT_B +: 8];  // R14
  assign port_c_pull_up = pull_up_all[8*`TPG_PORT_C +: 8];
  assign port_d_pull_up = pull_up_all[8*`TPG_PORT_D +: 8];

endmodule // tpg_top
